// ---- logic/bsc_pkg.sv ----
// Constants and types shared by the bus space configuration block
package bsc_pkg;
   // Register byte offsets on the APB
   localparam logic [7:0] SSC_OFFSET = 8'h00;
   localparam logic [7:0] BCC_OFFSET = 8'h04;
   localparam logic [7:0] RFC_OFFSET = 8'h08;
   // System space control fields
   localparam int SSC_FLASH_SEL_BIT = 3;
   localparam int SSC_RESERVED_BIT = 2;
   localparam int SSC_EXT_BUS_BIT = 1;
   localparam int SSC_RAM_BIT = 0;
   localparam logic SSC_FLASH_SEL_RESET = 1'b0;
   localparam logic SSC_EXT_BUS_RESET = 1'b0;
   localparam logic SSC_RAM_RESET = 1'b1;
   // Bus cycle control fields
   localparam int BCC_IDLE_RW_BIT = 10;
   localparam int BCC_WBUF_BIT = 9;
   localparam int BCC_WAIT_BIT = 8;
   localparam int BCC_IDLE_WR_BIT = 2;
   localparam logic [15:0] BCC_RESET = 16'h0400;
   localparam logic [15:0] BCC_WRITABLE = 16'h07ff;
   // Refresh control fields
   localparam int RFC_DELAY_LSB = 0;
   localparam int RFC_WIDTH_LSB = 2;
   localparam logic [3:0] RFC_RESET = 4'h0;
   // Flash control register window
   localparam logic [23:0] FLASH_WIN_LO = 24'hff_ffc8;
   localparam logic [23:0] FLASH_WIN_HI = 24'hff_ffcb;
   // Inserted idle cycle length in clocks
   localparam int IDLE_GAP_CYCLES = 1;
   typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_ACCESS, ST_REFRESH} bsc_state_type;
   typedef enum logic [1:0] {KIND_NONE, KIND_READ, KIND_WRITE} bsc_kind_type;
   typedef enum logic [1:0] {SEL_NONE, SEL_SSC, SEL_BCC, SEL_RFC} bsc_sel_type;
   typedef enum logic [1:0] {RS_IDLE, RS_DELAY, RS_ACTIVE} bsc_rs_state_type;
endpackage

// ---- logic/bsc_refresh_strobe.sv ----
// Row strobe delay and width timer used only for refresh
`timescale 1ns/1ps
module bsc_refresh_strobe (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [1:0] delay_code,
   input wire logic [1:0] width_code,
   output logic row_strobe_n,
   output logic done
);
   bsc_pkg::bsc_rs_state_type state;
   logic [2:0] cnt;
   logic [1:0] width_hold;

   // Codes 00 and 01 give one and two cycles, 10 and 11 three
   function automatic logic [2:0] delay_cycles(input logic [1:0] code);
      delay_cycles = (code == 2'b00) ? 3'd1 : ((code == 2'b01) ? 3'd2 : 3'd3);
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= bsc_pkg::RS_IDLE;
         cnt <= 3'd0;
         width_hold <= 2'b00;
         row_strobe_n <= 1'b1;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            bsc_pkg::RS_IDLE: begin
               if (start) begin
                  cnt <= delay_cycles(delay_code) - 3'd1;
                  width_hold <= width_code;
                  state <= bsc_pkg::RS_DELAY;
               end
            end
            bsc_pkg::RS_DELAY: begin
               if (cnt == 3'd0) begin
                  row_strobe_n <= 1'b0;
                  cnt <= {1'b0, width_hold};
                  state <= bsc_pkg::RS_ACTIVE;
               end else begin
                  cnt <= cnt - 3'd1;
               end
            end
            default: begin
               if (cnt == 3'd0) begin
                  row_strobe_n <= 1'b1;
                  done <= 1'b1;
                  state <= bsc_pkg::RS_IDLE;
               end else begin
                  cnt <= cnt - 3'd1;
               end
            end
         endcase
      end
   end

   default clocking rs_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_delay_two: assert property (
      (start && state == bsc_pkg::RS_IDLE && delay_code == 2'b01)
      |=> row_strobe_n ##1 row_strobe_n ##1 !row_strobe_n)
      else $error("refresh strobe delay of two cycles not met");
   a_width_two: assert property (
      ($fell(row_strobe_n) && width_hold == 2'b01) |-> !row_strobe_n [*2] ##1 row_strobe_n)
      else $error("refresh strobe width of two cycles not met");
endmodule // bsc_refresh_strobe

// ---- logic/bsc_bus_space_config.sv ----
// Bus space configuration registers with external bus cycle sequencer
// Function
// - Flash select maps window FFFFC8 to FFFFCB
// - Flash select clear deselects, keeps contents
// - System control bit 2 reads zero
// - Modes 1,2,4,5,6 force external bus on
// - Modes 3,7 external bus reset zero, writable
// - External bus enable bit gates bus cycles
// - RAM enable bit drives RAM, resets one
// - RAM enable reinitialised at reset release
// - Idle cycle between read then write
// - Idle cycle between write then read
// - Write buffer posts writes and single DMA
// - Wait enable honours or ignores wait pin
// - Refresh row strobe delayed one to three
// - Refresh row strobe width from setting
// - Strobe settings affect refresh only
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module bsc_bus_space_config (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] op_mode,
   input wire logic [23:0] cpu_addr,
   input wire logic ext_req,
   input wire logic ext_req_write,
   input wire logic ext_req_dma_single,
   input wire logic ext_wait_n,
   input wire logic refresh_req,
   output logic ext_ack,
   output logic ext_err,
   output logic rd_strobe,
   output logic wr_strobe,
   output logic idle_cycle,
   output logic refresh_ack,
   output logic row_strobe_n,
   output logic flash_ctrl_hit,
   output logic flash_ctrl_sel_out,
   output logic ext_bus_enable,
   output logic onchip_ram_enable_out,
   output logic wait_pin_gpio
);
   logic flash_ctrl_reg_select;
   logic ext_bus_mode_reg;
   logic onchip_ram_enable;
   logic [15:0] bus_cycle_control;
   logic [3:0] refresh_control_reg;
   logic ext_mode_value;
   logic apb_setup;
   logic apb_commit;
   bsc_pkg::bsc_sel_type rd_sel;
   bsc_pkg::bsc_sel_type wr_sel;
   logic [31:0] next_rdata;
   bsc_pkg::bsc_state_type state;
   bsc_pkg::bsc_kind_type last_kind;
   logic take;
   logic need_gap;
   logic pend_write;
   logic pend_posted;
   logic wait_hold;
   logic rs_start;
   logic rs_done;
   logic rs_row_n;

   function automatic bsc_pkg::bsc_sel_type reg_decode(input logic [7:0] addr);
      if (addr == bsc_pkg::SSC_OFFSET) begin
         reg_decode = bsc_pkg::SEL_SSC;
      end else if (addr == bsc_pkg::BCC_OFFSET) begin
         reg_decode = bsc_pkg::SEL_BCC;
      end else if (addr == bsc_pkg::RFC_OFFSET) begin
         reg_decode = bsc_pkg::SEL_RFC;
      end else begin
         reg_decode = bsc_pkg::SEL_NONE;
      end
   endfunction

   // Modes with the external bus fixed on
   function automatic logic ext_fixed(input logic [2:0] mode);
      ext_fixed = (mode == 3'd1) || (mode == 3'd2) || (mode == 3'd4) ||
                  (mode == 3'd5) || (mode == 3'd6);
   endfunction

   // Two-cycle access phase keeps read data straight from a flop
   assign apb_setup = psel && penable && !pready;
   assign apb_commit = psel && penable && pready;
   assign rd_sel = reg_decode(paddr);
   assign wr_sel = reg_decode(paddr);

   assign ext_mode_value = ext_fixed(op_mode) | ext_bus_mode_reg;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd_sel == bsc_pkg::SEL_SSC) begin
         next_rdata[bsc_pkg::SSC_FLASH_SEL_BIT] = flash_ctrl_reg_select;
         next_rdata[bsc_pkg::SSC_RESERVED_BIT] = 1'b0;
         next_rdata[bsc_pkg::SSC_EXT_BUS_BIT] = ext_mode_value;
         next_rdata[bsc_pkg::SSC_RAM_BIT] = onchip_ram_enable;
      end else if (rd_sel == bsc_pkg::SEL_BCC) begin
         next_rdata[15:0] = bus_cycle_control;
      end else if (rd_sel == bsc_pkg::SEL_RFC) begin
         next_rdata[3:0] = refresh_control_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && (rd_sel == bsc_pkg::SEL_NONE);
         prdata <= (apb_setup && !pwrite) ? next_rdata : 32'h0000_0000;
      end
   end

   // System space control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_ctrl_reg_select <= bsc_pkg::SSC_FLASH_SEL_RESET;
         ext_bus_mode_reg <= bsc_pkg::SSC_EXT_BUS_RESET;
         onchip_ram_enable <= bsc_pkg::SSC_RAM_RESET;
      end else if (apb_commit && pwrite && wr_sel == bsc_pkg::SEL_SSC) begin
         flash_ctrl_reg_select <= pwdata[bsc_pkg::SSC_FLASH_SEL_BIT];
         if (!ext_fixed(op_mode)) begin
            ext_bus_mode_reg <= pwdata[bsc_pkg::SSC_EXT_BUS_BIT];
         end
         onchip_ram_enable <= pwdata[bsc_pkg::SSC_RAM_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_cycle_control <= bsc_pkg::BCC_RESET;
      end else if (apb_commit && pwrite && wr_sel == bsc_pkg::SEL_BCC) begin
         bus_cycle_control <= pwdata[15:0] & bsc_pkg::BCC_WRITABLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refresh_control_reg <= bsc_pkg::RFC_RESET;
      end else if (apb_commit && pwrite && wr_sel == bsc_pkg::SEL_RFC) begin
         refresh_control_reg <= pwdata[3:0];
      end
   end

   // Configuration outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_ctrl_hit <= 1'b0;
         flash_ctrl_sel_out <= 1'b0;
         ext_bus_enable <= 1'b0;
         onchip_ram_enable_out <= 1'b1;
         wait_pin_gpio <= 1'b1;
      end else begin
         flash_ctrl_hit <= flash_ctrl_reg_select &&
                           (cpu_addr >= bsc_pkg::FLASH_WIN_LO) &&
                           (cpu_addr <= bsc_pkg::FLASH_WIN_HI);
         flash_ctrl_sel_out <= flash_ctrl_reg_select;
         ext_bus_enable <= ext_mode_value;
         onchip_ram_enable_out <= onchip_ram_enable;
         wait_pin_gpio <= !bus_cycle_control[bsc_pkg::BCC_WAIT_BIT];
      end
   end

   // Ack still high means the requester has not yet moved on
   assign take = ext_req && !ext_ack && !(refresh_req && !refresh_ack);
   assign need_gap = (last_kind == bsc_pkg::KIND_READ && ext_req_write &&
                      bus_cycle_control[bsc_pkg::BCC_IDLE_RW_BIT]) ||
                     (last_kind == bsc_pkg::KIND_WRITE && !ext_req_write &&
                      bus_cycle_control[bsc_pkg::BCC_IDLE_WR_BIT]);
   assign wait_hold = bus_cycle_control[bsc_pkg::BCC_WAIT_BIT] && !ext_wait_n;
   assign rs_start = (state == bsc_pkg::ST_IDLE) && refresh_req && !refresh_ack &&
                     ext_bus_enable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= bsc_pkg::ST_IDLE;
         last_kind <= bsc_pkg::KIND_NONE;
         pend_write <= 1'b0;
         pend_posted <= 1'b0;
         ext_ack <= 1'b0;
         ext_err <= 1'b0;
         rd_strobe <= 1'b0;
         wr_strobe <= 1'b0;
         idle_cycle <= 1'b0;
         refresh_ack <= 1'b0;
      end else begin
         ext_ack <= 1'b0;
         ext_err <= 1'b0;
         idle_cycle <= 1'b0;
         refresh_ack <= 1'b0;
         case (state)
            bsc_pkg::ST_IDLE: begin
               if (rs_start) begin
                  state <= bsc_pkg::ST_REFRESH;
               end else if (take && !ext_bus_enable) begin
                  ext_ack <= 1'b1;
                  ext_err <= 1'b1;
               end else if (take) begin
                  pend_write <= ext_req_write;
                  pend_posted <= bus_cycle_control[bsc_pkg::BCC_WBUF_BIT] &&
                                 (ext_req_write || ext_req_dma_single);
                  if (need_gap) begin
                     idle_cycle <= 1'b1;
                     state <= bsc_pkg::ST_GAP;
                  end else begin
                     rd_strobe <= !ext_req_write;
                     wr_strobe <= ext_req_write;
                     ext_ack <= bus_cycle_control[bsc_pkg::BCC_WBUF_BIT] &&
                                (ext_req_write || ext_req_dma_single);
                     state <= bsc_pkg::ST_ACCESS;
                  end
               end else if (!ext_req && !ext_ack) begin
                  last_kind <= bsc_pkg::KIND_NONE;
               end
            end
            bsc_pkg::ST_GAP: begin
               rd_strobe <= !pend_write;
               wr_strobe <= pend_write;
               ext_ack <= pend_posted;
               state <= bsc_pkg::ST_ACCESS;
            end
            bsc_pkg::ST_ACCESS: begin
               if (!wait_hold) begin
                  rd_strobe <= 1'b0;
                  wr_strobe <= 1'b0;
                  ext_ack <= !pend_posted;
                  last_kind <= pend_write ? bsc_pkg::KIND_WRITE : bsc_pkg::KIND_READ;
                  state <= bsc_pkg::ST_IDLE;
               end
            end
            default: begin
               if (rs_done) begin
                  refresh_ack <= 1'b1;
                  last_kind <= bsc_pkg::KIND_NONE;
                  state <= bsc_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // Strobe timing used by refresh only
   bsc_refresh_strobe u_refresh_strobe (
      .pclk(pclk),
      .presetn(presetn),
      .start(rs_start),
      .delay_code(refresh_control_reg[bsc_pkg::RFC_DELAY_LSB +: 2]),
      .width_code(refresh_control_reg[bsc_pkg::RFC_WIDTH_LSB +: 2]),
      .row_strobe_n(rs_row_n),
      .done(rs_done)
   );
   assign row_strobe_n = rs_row_n;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_reserved_reads_zero: assert property (
      (apb_setup && !pwrite && rd_sel == bsc_pkg::SEL_SSC) |=> pready && !prdata[2])
      else $error("reserved system control bit read as one");
   a_flash_window_hit: assert property (
      (flash_ctrl_reg_select && cpu_addr == bsc_pkg::FLASH_WIN_HI) |=> flash_ctrl_hit)
      else $error("flash control window not selected");
   a_flash_deselect: assert property (
      !flash_ctrl_reg_select |=> !flash_ctrl_hit)
      else $error("flash control window hit while deselected");
   a_ext_fixed_on: assert property (
      (ext_fixed(op_mode) && $stable(op_mode)) |=> ext_bus_enable)
      else $error("external bus not forced on in fixed mode");
   a_ext_writable: assert property (
      (apb_commit && pwrite && wr_sel == bsc_pkg::SEL_SSC && !ext_fixed(op_mode))
      |=> ext_bus_mode_reg == $past(pwdata[1]))
      else $error("external bus bit write lost in writable mode");
   a_bus_refused: assert property (
      (state == bsc_pkg::ST_IDLE && !rs_start && take && !ext_bus_enable)
      |=> ext_err && ext_ack && !rd_strobe && !wr_strobe)
      else $error("cycle started on disabled external bus");
   a_ram_follows: assert property (
      $changed(onchip_ram_enable) |=> onchip_ram_enable_out == $past(onchip_ram_enable))
      else $error("RAM enable output does not follow its bit");
   a_gap_read_write: assert property (
      (state == bsc_pkg::ST_IDLE && !rs_start && take && ext_bus_enable &&
       ext_req_write && last_kind == bsc_pkg::KIND_READ &&
       bus_cycle_control[bsc_pkg::BCC_IDLE_RW_BIT]) |=> idle_cycle ##1 wr_strobe)
      else $error("no idle cycle between read and write");
   a_gap_write_read: assert property (
      (state == bsc_pkg::ST_IDLE && !rs_start && take && ext_bus_enable &&
       !ext_req_write && last_kind == bsc_pkg::KIND_WRITE &&
       bus_cycle_control[bsc_pkg::BCC_IDLE_WR_BIT]) |=> idle_cycle ##1 rd_strobe)
      else $error("no idle cycle between write and read");
   a_posted_ack: assert property (
      (state == bsc_pkg::ST_IDLE && !rs_start && take && ext_bus_enable && !need_gap &&
       ext_req_write && bus_cycle_control[bsc_pkg::BCC_WBUF_BIT]) |=> ext_ack && wr_strobe)
      else $error("buffered write not acknowledged at start");
   a_wait_ignored: assert property (
      (state == bsc_pkg::ST_ACCESS && !bus_cycle_control[bsc_pkg::BCC_WAIT_BIT])
      |=> !rd_strobe && !wr_strobe)
      else $error("wait honoured while disabled");
   a_refresh_only: assert property (
      (rd_strobe || wr_strobe) |-> row_strobe_n)
      else $error("row strobe active during normal access");
   a_gap_quiet: assert property (
      idle_cycle |-> !rd_strobe && !wr_strobe ##1 !idle_cycle)
      else $error("strobe during inserted idle cycle");
   a_posted_dma: assert property (
      (state == bsc_pkg::ST_IDLE && !rs_start && take && ext_bus_enable && !need_gap &&
       ext_req_dma_single && bus_cycle_control[bsc_pkg::BCC_WBUF_BIT]) |=> ext_ack)
      else $error("buffered single DMA cycle not acknowledged at start");
   a_ack_pulse: assert property (
      ext_ack |=> !ext_ack)
      else $error("external acknowledge held for more than one cycle");
   a_wait_honoured: assert property (
      (state == bsc_pkg::ST_ACCESS && wait_hold)
      |=> (rd_strobe || wr_strobe) && state == bsc_pkg::ST_ACCESS)
      else $error("access ended while wait input held it");
endmodule // bsc_bus_space_config

// ---- sim/bsc_ext_model.sv ----
// External memory model that answers bus strobes, optionally with wait
`timescale 1ns/1ps
module bsc_ext_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic slow,
   output logic ext_wait_n
);
   logic [1:0] held;
   // Counts strobe cycles so a slow device stalls the first two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held <= 2'h0;
      end else if (rd_strobe || wr_strobe) begin
         if (held != 2'h3) begin
            held <= held + 2'h1;
         end
      end else begin
         held <= 2'h0;
      end
   end
   // Pull-up on the wait line: high whenever no access is stalled
   assign ext_wait_n = !(slow && (rd_strobe || wr_strobe) && held < 2'h2);
endmodule // bsc_ext_model

// ---- sim/bsc_bus_space_config_bench.sv ----
// Self-checking bench for the bus space configuration block
`timescale 1ns/1ps
module bsc_bus_space_config_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [2:0] op_mode = 3'h7;
   logic [23:0] cpu_addr = 24'h00_0000;
   logic ext_req = 1'b0, ext_req_write = 1'b0, ext_req_dma_single = 1'b0;
   logic refresh_req = 1'b0, slow = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, ext_wait_n, ext_ack, ext_err, rd_strobe, wr_strobe;
   logic idle_cycle, refresh_ack, row_strobe_n, flash_ctrl_hit, flash_ctrl_sel_out;
   logic ext_bus_enable, onchip_ram_enable_out, wait_pin_gpio;
   logic [32:0] apb_q[$];
   logic [7:0] ext_q[$];
   logic [1:0] n_idle = 2'h0;
   logic [3:0] n_rd = 4'h0;
   logic [31:0] v;
   logic [2:0] modes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
   int err_count = 0;
   int tests_run = 0;

   always #20 pclk = ~pclk;

   bsc_bus_space_config dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .op_mode, .cpu_addr, .ext_req, .ext_req_write, .ext_req_dma_single,
      .ext_wait_n, .refresh_req, .ext_ack, .ext_err, .rd_strobe, .wr_strobe,
      .idle_cycle, .refresh_ack, .row_strobe_n, .flash_ctrl_hit, .flash_ctrl_sel_out,
      .ext_bus_enable, .onchip_ram_enable_out, .wait_pin_gpio
   );

   bsc_ext_model mem (.pclk, .presetn, .rd_strobe, .wr_strobe, .slow, .ext_wait_n);

   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic reset(input logic [2:0] m);
      op_mode <= m;
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   // Request held until pready is seen at an edge, psel and penable released together
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic err, input logic [31:0] exp);
      apb_q.push_back({err, exp});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Expected note: {err, strobe at ack, idle count, read strobe cycles}
   task automatic ext(input logic wr, input logic dma, input logic keep, input logic [7:0] exp);
      ext_q.push_back(exp);
      ext_req <= 1'b1;
      ext_req_write <= wr;
      ext_req_dma_single <= dma;
      do @(posedge pclk); while (ext_ack !== 1'b1);
      if (!keep) begin
         ext_req <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task automatic refresh(input logic [1:0] d, input logic [1:0] w);
      int n;
      apb(1'b1, bsc_pkg::RFC_OFFSET, {28'h0, w, d}, 1'b0, 32'h0000_0000);
      refresh_req <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (row_strobe_n !== 1'b0 && n < 20);
      check("row delay", n, (d == 2'h0) ? 3 : (d == 2'h1) ? 4 : 5);
      n = 0;
      do begin @(posedge pclk); n++; end while (row_strobe_n === 1'b0 && n < 20);
      check("row width", n, w + 1);
      n = 0;
      // Done leaves with the strobe release, ack follows one clock later
      do begin @(posedge pclk); n++; end while (refresh_ack !== 1'b1 && n < 20);
      check("refresh ack", n, 1);
      refresh_req <= 1'b0;
      @(posedge pclk);
   endtask

   // Results are taken off the queues as they appear at the ports
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         check("apb", {pslverr, prdata}, apb_q.pop_front());
      end
      if (ext_ack === 1'b1) begin
         check("ext", {ext_err, rd_strobe | wr_strobe, n_idle, n_rd}, ext_q.pop_front());
         n_idle = 2'h0;
         n_rd = 4'h0;
      end else begin
         if (idle_cycle === 1'b1) n_idle++;
         if (rd_strobe === 1'b1) n_rd++;
      end
   end

   initial begin
      repeat (5000) @(posedge pclk);
      err_count++;
      end_sim();
   end

   initial begin
      void'($urandom(43147));
      reset(3'h7);
      apb(1'b0, bsc_pkg::SSC_OFFSET, 32'h0, 1'b0, 32'h0000_0001);
      apb(1'b0, bsc_pkg::BCC_OFFSET, 32'h0, 1'b0, 32'h0000_0400);
      apb(1'b0, bsc_pkg::RFC_OFFSET, 32'h0, 1'b0, 32'h0000_0000);
      check("bus enable", ext_bus_enable, 1'b0);
      check("ram enable", onchip_ram_enable_out, 1'b1);
      check("wait gpio", wait_pin_gpio, 1'b1);
      check("flash select", flash_ctrl_sel_out, 1'b0);
      ext(1'b0, 1'b0, 1'b0, 8'h80);
      apb(1'b1, bsc_pkg::SSC_OFFSET, 32'h0000_00ff, 1'b0, 32'h0000_0000);
      apb(1'b0, bsc_pkg::SSC_OFFSET, 32'h0, 1'b0, 32'h0000_000b);
      check("bus enable", ext_bus_enable, 1'b1);
      for (logic [23:0] a = 24'hff_ffc6; a <= 24'hff_ffcd; a++) begin
         cpu_addr <= a;
         repeat (2) @(posedge pclk);
         check("flash hit", flash_ctrl_hit, a >= 24'hff_ffc8 && a <= 24'hff_ffcb);
      end
      cpu_addr <= 24'hff_ffc9;
      apb(1'b1, bsc_pkg::SSC_OFFSET, 32'h0000_0003, 1'b0, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      check("flash off", {flash_ctrl_hit, flash_ctrl_sel_out}, 2'h0);
      apb(1'b1, 8'h0c, 32'hffff_ffff, 1'b1, 32'h0000_0000);
      apb(1'b0, 8'h0c, 32'h0, 1'b1, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         apb(1'b1, bsc_pkg::BCC_OFFSET, v, 1'b0, 32'h0000_0000);
         apb(1'b0, bsc_pkg::BCC_OFFSET, 32'h0, 1'b0, {16'h0, v[15:0] & 16'h07ff});
      end
      for (int d = 0; d < 4; d++) refresh(d[1:0], 2'(3 - d));
      apb(1'b1, bsc_pkg::BCC_OFFSET, 32'h0000_0400, 1'b0, 32'h0000_0000);
      ext(1'b0, 1'b0, 1'b1, 8'h01);
      ext(1'b1, 1'b0, 1'b0, 8'h10);
      apb(1'b1, bsc_pkg::BCC_OFFSET, 32'h0000_0004, 1'b0, 32'h0000_0000);
      ext(1'b1, 1'b0, 1'b1, 8'h00);
      ext(1'b0, 1'b0, 1'b1, 8'h11);
      ext(1'b1, 1'b0, 1'b0, 8'h00);
      apb(1'b1, bsc_pkg::BCC_OFFSET, 32'h0000_0200, 1'b0, 32'h0000_0000);
      ext(1'b1, 1'b0, 1'b0, 8'h40);
      ext(1'b0, 1'b1, 1'b0, 8'h40);
      ext(1'b0, 1'b0, 1'b0, 8'h01);
      slow <= 1'b1;
      apb(1'b1, bsc_pkg::BCC_OFFSET, 32'h0000_0100, 1'b0, 32'h0000_0000);
      // Pin output lags the register by one clock
      @(posedge pclk);
      check("wait gpio", wait_pin_gpio, 1'b0);
      ext(1'b0, 1'b0, 1'b0, 8'h03);
      apb(1'b1, bsc_pkg::BCC_OFFSET, 32'h0000_0000, 1'b0, 32'h0000_0000);
      ext(1'b0, 1'b0, 1'b0, 8'h01);
      apb(1'b1, bsc_pkg::SSC_OFFSET, 32'h0000_0001, 1'b0, 32'h0000_0000);
      ext(1'b0, 1'b0, 1'b0, 8'h80);
      for (int i = 0; i < 5; i++) begin
         reset(modes[i]);
         check("fixed bus", ext_bus_enable, 1'b1);
         apb(1'b1, bsc_pkg::SSC_OFFSET, 32'h0000_0000, 1'b0, 32'h0000_0000);
         apb(1'b0, bsc_pkg::SSC_OFFSET, 32'h0, 1'b0, 32'h0000_0002);
         check("ram off", onchip_ram_enable_out, 1'b0);
      end
      reset(3'h3);
      check("ram reinit", onchip_ram_enable_out, 1'b1);
      apb(1'b0, bsc_pkg::SSC_OFFSET, 32'h0, 1'b0, 32'h0000_0001);
      repeat (4) @(posedge pclk);
      end_sim();
   end
endmodule // bsc_bus_space_config_bench
